/* File: src/bridge_pkg.sv */
// Constants, register map and carriers for the bridge PWM output stage.
// Assumes one 40 MHz clock and an Avalon-MM host with 32-bit data.
package bridge_pkg;
  // ****************************************
  // Register offsets (byte addresses).
  // ****************************************
  localparam logic [4:0] REG_MODE = 5'h00;
  localparam logic [4:0] REG_PERIOD = 5'h04;
  localparam logic [4:0] REG_DUTY = 5'h08;
  localparam logic [4:0] REG_DEADBAND = 5'h0C;
  localparam logic [4:0] REG_SHUTDOWN = 5'h10;
  localparam logic [4:0] REG_STATUS = 5'h14;
  // ****************************************
  // Field positions and codes.
  // ****************************************
  localparam int MODE_LSB = 6;
  localparam int EN_LSB = 2;
  localparam int AUTO_BIT = 7;
  localparam int STAT_BIT = 7;
  localparam int SRC_LSB = 4;
  localparam int AC_LSB = 2;
  localparam logic [1:0] RUN_CODE = 2'h3;
  localparam logic [1:0] SD_LOW = 2'h0;
  localparam logic [1:0] SD_HIGH = 2'h1;
  localparam logic [7:0] EARLY_COUNTS = 8'h3;
  localparam logic [1:0] LAST_PHASE = 2'h3;
  localparam logic [7:0] PERIOD_RESET = 8'hFF;
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_FWD = 2'h1,
    MODE_HALF = 2'h2,
    MODE_REV = 2'h3
  } out_mode_e;
  // Pin carrier: level and drive enable for A..D (bit 0 is A).
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] oe;
  } pins_s;
endpackage

/* File: src/bridge_pwm_output_shutdown.sv */
// Enhanced PWM output stage with dead-band, full-bridge steering
// and auto-shutdown, behind an Avalon-MM slave with waitrequest.
// Assumes pin inputs synchronous to clk_sys; pin direction lives outside.
`timescale 1ns/1ps
module bridge_pwm_output_shutdown (
  input wire logic clk_sys, // System clock, 40 MHz.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic [4:0] address, // Byte address.
  input wire logic read, // Read request.
  input wire logic write, // Write request.
  input wire logic [31:0] writedata, // Write data.
  output logic [31:0] readdata, // Read data.
  output logic waitrequest, // Stall while high.
  input wire logic fault_input_pin_b, // Fault pin, low means fault.
  input wire logic first_comparator_output, // Comparator, high means fault.
  output bridge_pkg::pins_s bridge_pins // Levels and enables A..D.
);
  import bridge_pkg::*;

  // ****************************************
  // Register state.
  // ****************************************
  logic [7:0] mode_q; // Mode, enable and polarity bits.
  logic [7:0] period_register_q; // Period in timer counts.
  logic [9:0] duty_q; // Duty in clock cycles.
  logic [7:0] deadband_restart_control_q; // Restart bit and dead-band.
  logic [6:0] shutdown_control_q; // Sources and pair states.
  logic shutdown_event_status_q; // Shutdown status.
  logic ack_q; // Second bus cycle marker.
  logic [31:0] readdata_q; // Registered read data.

  // ****************************************
  // Bus decode.
  // ****************************************
  // One wait cycle per access keeps read data registered.
  wire req = read | write;
  wire wr_go = write & ack_q;
  wire wr_mode = wr_go & (address == REG_MODE);
  wire wr_period = wr_go & (address == REG_PERIOD);
  wire wr_duty = wr_go & (address == REG_DUTY);
  wire wr_db = wr_go & (address == REG_DEADBAND);
  wire wr_sd = wr_go & (address == REG_SHUTDOWN);
  assign waitrequest = req & ~ack_q;
  assign readdata = readdata_q;

  // Field views.
  // output mode field
  wire [1:0] output_mode_field = mode_q[MODE_LSB +: 2];
  wire direction_select_bit = output_mode_field[1];
  wire [1:0] mode_polarity_low = mode_q[1:0];
  wire run_en = (mode_q[EN_LSB +: 2] == RUN_CODE);
  wire [6:0] deadband_count = deadband_restart_control_q[6:0];
  wire auto_restart_enable = deadband_restart_control_q[AUTO_BIT];
  wire [2:0] shutdown_source_select = shutdown_control_q[SRC_LSB +: 3];
  wire [1:0] pair_ac_shutdown_state = shutdown_control_q[AC_LSB +: 2];
  wire [1:0] pair_bd_shutdown_state = shutdown_control_q[1:0];
  wire is_full = (output_mode_field == MODE_FWD) | (output_mode_field == MODE_REV);
  wire is_half = (output_mode_field == MODE_HALF);

  // ****************************************
  // Period timer.
  // ****************************************
  logic [1:0] phase_q; // Clock within one timer count.
  logic [7:0] period_timer_q; // Timer count.
  logic run_q; // Waveform running since a period start.
  logic pwm_q; // Modulated level, active high.
  logic pwm_prev_q; // Previous modulated level.
  wire instr_tick = (phase_q == LAST_PHASE);
  wire period_end = run_en & instr_tick & (period_timer_q == period_register_q);
  wire pwm_d = run_en & ({period_timer_q, phase_q} < duty_q);

  // Counter restarts at each period end, so waveforms are whole.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= 2'h0;
      period_timer_q <= 8'h0;
      run_q <= 1'b0;
    end else if (!run_en) begin
      phase_q <= 2'h0;
      period_timer_q <= 8'h0;
      run_q <= 1'b0;
    end else begin
      phase_q <= phase_q + 2'h1;
      if (period_end) begin
        period_timer_q <= 8'h0;
        run_q <= 1'b1;
      end else if (instr_tick) begin
        period_timer_q <= period_timer_q + 8'h1;
      end
    end
  end

  // Registered modulated level, held off until the first period start.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pwm_q <= 1'b0;
      pwm_prev_q <= 1'b0;
    end else begin
      pwm_q <= pwm_d & (run_q | period_end);
      pwm_prev_q <= pwm_q;
    end
  end

  // ****************************************
  // Dead-band counter.
  // ****************************************
  logic [8:0] db_cnt_q; // Clocks since the last edge, the edge clock counted as one.
  wire pwm_edge = pwm_q ^ pwm_prev_q;
  wire [8:0] db_span = {deadband_count, 2'h0}; // Dead-band in clocks, four per unit.
  wire db_ok = pwm_edge ? (deadband_count == 7'h0) : (db_cnt_q >= db_span);

  // Counting clocks rather than timer phases keeps the delay exact,
  // whichever phase of the timer the edge happens to fall on.
  // saturating count
  // Saturates, so a count past the dead-band never wraps and blocks the output again.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      db_cnt_q <= 9'h000;
    end else if (pwm_edge) begin
      db_cnt_q <= 9'h001;
    end else if (db_cnt_q != 9'h1FF) begin
      db_cnt_q <= db_cnt_q + 9'h001;
    end
  end

  // ****************************************
  // Direction change.
  // ****************************************
  logic dir_q; // Direction applied, 1 is reverse.
  logic blank_q; // Modulated outputs forced off.
  wire early_pt = (period_register_q < EARLY_COUNTS) ? period_end :
    (run_en & (phase_q == 2'h0) & (period_timer_q == period_register_q - EARLY_COUNTS));
  wire dir_change = is_full & (direction_select_bit != dir_q);

  // Outside full-bridge the direction just follows the bit.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dir_q <= 1'b0;
      blank_q <= 1'b0;
    end else if (!is_full || !run_q) begin
      dir_q <= direction_select_bit;
      blank_q <= 1'b0;
    end else if (dir_change && early_pt) begin
      dir_q <= direction_select_bit;
      blank_q <= 1'b1;
    end else if (period_end) begin
      blank_q <= 1'b0;
    end
  end

  // ****************************************
  // Output mode steering (active-high view).
  // ****************************************
  logic [3:0] act_d; // Active levels A..D.
  logic [3:0] act_q; // Registered active levels.
  logic [3:0] mode_oe; // Pins owned by the mode.
  wire pwm_mod = pwm_q & ~blank_q;

  // Selects which pins carry what in each mode.
  always_comb begin
    act_d = 4'h0;
    mode_oe = 4'h0;
    case (output_mode_field)
      MODE_SINGLE: begin
        act_d = {3'h0, pwm_q};
        mode_oe = 4'h1;
      end
      MODE_HALF: begin
        act_d = {2'h0, ~pwm_q & db_ok & run_q, pwm_q & db_ok};
        mode_oe = 4'h3;
      end
      default: begin
        mode_oe = 4'hF;
        if (!dir_q) begin
          act_d = {pwm_mod, 2'h0, run_q};
        end else begin
          act_d = {1'b0, run_q, pwm_mod, 1'b0};
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      act_q <= 4'h0;
    end else begin
      act_q <= act_d & {4{run_en}};
    end
  end

  // ****************************************
  // Auto-shutdown.
  // ****************************************
  logic hold_q; // Outputs held off until a period start.
  wire hw_evt = (shutdown_source_select[1] & ~fault_input_pin_b) |
    (shutdown_source_select[0] & first_comparator_output);
  wire sw_set = wr_sd & writedata[STAT_BIT];
  wire sw_clr = wr_sd & ~writedata[STAT_BIT];
  wire shut = hw_evt | shutdown_event_status_q | hold_q;

  // The set terms win over every clear term.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      shutdown_event_status_q <= 1'b0;
    end else if (hw_evt || sw_set) begin
      shutdown_event_status_q <= 1'b1;
    end else if (sw_clr || auto_restart_enable) begin
      shutdown_event_status_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hold_q <= 1'b0;
    end else if (hw_evt || shutdown_event_status_q || sw_set) begin
      hold_q <= 1'b1;
    end else if (period_end || !run_en) begin
      hold_q <= 1'b0;
    end
  end

  // ****************************************
  // Pin drive.
  // ****************************************
  // Shutdown acts combinationally, so a fault reaches the pins
  // in the same cycle rather than after a flop.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      wire pol_low = (gi % 2 == 1) ? mode_polarity_low[0] : mode_polarity_low[1];
      wire [1:0] sd_st = (gi % 2 == 1) ? pair_bd_shutdown_state : pair_ac_shutdown_state;
      wire sd_drive = (sd_st == SD_LOW) | (sd_st == SD_HIGH);
      wire run_lvl = act_q[gi] ^ pol_low;
      assign bridge_pins.level[gi] = shut ? (sd_st == SD_HIGH) : run_lvl;
      assign bridge_pins.oe[gi] = mode_oe[gi] & run_en & (~shut | sd_drive);
    end
  endgenerate

  // ****************************************
  // Register writes and reads.
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= 8'h0;
      period_register_q <= PERIOD_RESET;
      duty_q <= 10'h0;
      deadband_restart_control_q <= 8'h0;
      shutdown_control_q <= 7'h0;
    end else begin
      if (wr_mode) mode_q <= writedata[7:0];
      if (wr_period) period_register_q <= writedata[7:0];
      if (wr_duty) duty_q <= writedata[9:0];
      if (wr_db) deadband_restart_control_q <= writedata[7:0];
      if (wr_sd) shutdown_control_q <= writedata[6:0];
    end
  end

  // Read mux; unmapped addresses read zero.
  logic [31:0] rd_mux;
  always_comb begin
    case (address)
      REG_MODE: rd_mux = {24'h0, mode_q};
      REG_PERIOD: rd_mux = {24'h0, period_register_q};
      REG_DUTY: rd_mux = {22'h0, duty_q};
      REG_DEADBAND: rd_mux = {24'h0, deadband_restart_control_q};
      REG_SHUTDOWN: rd_mux = {24'h0, shutdown_event_status_q, shutdown_control_q};
      REG_STATUS: rd_mux = {12'h0, act_q, dir_q, blank_q, hold_q, hw_evt, 4'h0, period_timer_q};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      readdata_q <= 32'h0;
    end else begin
      ack_q <= req & ~ack_q;
      if (read && !ack_q) readdata_q <= rd_mux;
    end
  end

  // ****************************************
  // Checks.
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_rise_a;
    !pwm_prev_q ##1 pwm_q;
  endsequence
  property p_half_no_overlap;
    is_half |-> !(act_q[0] & act_q[1]);
  endproperty
  a_half_no_overlap: assert property (p_half_no_overlap) else $error("A and B both active");
  property p_deadband;
    (is_half && deadband_count > 7'h1) throughout s_rise_a |=> !act_q[0];
  endproperty
  a_deadband: assert property (p_deadband) else $error("Dead-band not applied");
  property p_forward;
    is_full && !dir_q && $past(is_full) && !$past(dir_q) |-> !act_q[1] && !act_q[2];
  endproperty
  a_forward: assert property (p_forward) else $error("Forward pattern wrong");
  property p_reverse;
    is_full && dir_q && $past(is_full) && $past(dir_q) |-> !act_q[0] && !act_q[3];
  endproperty
  a_reverse: assert property (p_reverse) else $error("Reverse pattern wrong");
  property p_swap_blank;
    is_full && run_q && $changed(dir_q) |-> blank_q ##1 (!act_q[1] && !act_q[3]);
  endproperty
  a_swap_blank: assert property (p_swap_blank) else $error("No blanking at swap");
  property p_fault_set;
    hw_evt |=> shutdown_event_status_q;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("Status not set");
  property p_immediate;
    hw_evt && mode_oe[0] && run_en && pair_ac_shutdown_state == SD_HIGH |->
      bridge_pins.level[0];
  endproperty
  a_immediate: assert property (p_immediate) else $error("Pin not forced");
  property p_write_blocked;
    hw_evt && sw_clr |=> shutdown_event_status_q;
  endproperty
  a_write_blocked: assert property (p_write_blocked) else $error("Clear accepted");
  property p_restart_edge;
    $fell(hold_q) |-> $past(period_end) || !$past(run_en);
  endproperty
  a_restart_edge: assert property (p_restart_edge) else $error("Mid-period restart");
  property p_sw_force;
    sw_set |=> shutdown_event_status_q && shut;
  endproperty
  a_sw_force: assert property (p_sw_force) else $error("Force ignored");
  property p_auto_clear;
    auto_restart_enable && !hw_evt && !sw_set && !(wr_db) |=> !shutdown_event_status_q;
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("Auto clear missing");

  // ****************************************
  // Pin ownership and shutdown source checks.
  // ****************************************
  // A tristate pair must let go of both pins, or the gate pull-downs lose.
  property p_tristate;
    shut && pair_bd_shutdown_state[1] |-> !bridge_pins.oe[1] && !bridge_pins.oe[3];
  endproperty
  a_tristate: assert property (p_tristate) else $error("Pair B/D still driven");
  property p_cmp_source;
    shutdown_source_select[0] && first_comparator_output |-> hw_evt && shut;
  endproperty
  a_cmp_source: assert property (p_cmp_source) else $error("Comparator ignored");
  // Single mode leaves B, C and D to other pin users.
  property p_single_only_a;
    output_mode_field == MODE_SINGLE |->
      !bridge_pins.oe[1] && !bridge_pins.oe[2] && !bridge_pins.oe[3];
  endproperty
  a_single_only_a: assert property (p_single_only_a) else $error("Single drives B-D");
endmodule

/* File: tb/bridge_load.sv */
// Behavioural model of the bridge gate drivers and the two fault sources.
// Assumes pin carriers from the output stage and fault requests from the bench.
`timescale 1ns/1ps
module bridge_load (
  input wire logic flt_req, // Bench asks for a fault pin event.
  input wire logic cmp_req, // Bench asks for a comparator event.
  input wire bridge_pkg::pins_s bridge_pins, // Pin levels and enables A..D.
  output logic fault_input_pin_b, // Fault pin, pulled up while idle.
  output logic first_comparator_output, // Comparator output, high on fault.
  output logic [3:0] pad // Gate level seen by each switch driver.
);
  import bridge_pkg::*;
  // ****************************************
  // Pin resolution and fault sources.
  // ****************************************
  // A released pin falls to the gate pull-down, so that switch stays off.
  assign pad = bridge_pins.level & bridge_pins.oe;
  assign fault_input_pin_b = ~flt_req;
  assign first_comparator_output = cmp_req;
endmodule

/* File: tb/bridge_pwm_output_shutdown_bench.sv */
// Self-checking bench for the bridge output stage, driven over Avalon-MM.
// Assumes the bridge_load model on the pins and one 40 MHz clock.
`timescale 1ns/1ps
module bridge_pwm_output_shutdown_bench;
  import bridge_pkg::*;
  logic clk_sys, rst_b, read, write, flt_req, cmp_req; // Bench drives these.
  logic [4:0] address; // Bus address.
  logic [31:0] writedata, readdata, q; // Bus data and last read value.
  logic waitrequest, fault_input_pin_b, first_comparator_output; // Status lines.
  pins_s bridge_pins; // Pins from the block.
  logic [3:0] pad; // Resolved pin levels.
  int err_total, cmp_count, cyc; // Counters.
  bridge_pwm_output_shutdown i_bridge_pwm_output_shutdown (.clk_sys(clk_sys), .rst_b(rst_b),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .fault_input_pin_b(fault_input_pin_b),
    .first_comparator_output(first_comparator_output), .bridge_pins(bridge_pins));
  bridge_load i_bridge_load (.flt_req(flt_req), .cmp_req(cmp_req), .bridge_pins(bridge_pins),
    .fault_input_pin_b(fault_input_pin_b),
    .first_comparator_output(first_comparator_output), .pad(pad));
  // ****************************************
  // Clock, timeout and closing report.
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // The ceiling is several times the expected run, so only a hang reaches it.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  // ****************************************
  // Bus, compare and pin tasks.
  // ****************************************
  // Holds the request until waitrequest is seen low at a rising edge.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Counts high clocks per pin over one 40-clock period; phase does not matter.
  task automatic pins(input int e [4]);
    logic [31:0] hi [4];
    hi = '{default: 32'h0};
    repeat (40) begin
      @(negedge clk_sys);
      for (int p = 0; p < 4; p++) hi[p] = hi[p] + 32'(pad[p]);
    end
    for (int p = 0; p < 4; p++) if (e[p] >= 0) chk(hi[p], e[p]);
  endtask
  // ****************************************
  // Test sequence.
  // ****************************************
  initial begin
    int exp_tab [4][4];
    exp_tab = '{'{12, -1, -1, -1}, '{40, 0, 0, 12}, '{8, 24, -1, -1}, '{0, 12, 40, 0}};
    {rst_b, read, write, flt_req, cmp_req} = 5'h00;
    address = 5'h00;
    writedata = 32'h0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    bus(1'b0, REG_PERIOD, 32'h0);
    chk(q, 32'(PERIOD_RESET));
    bus(1'b0, REG_SHUTDOWN, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 5'h18, 32'hFF);
    bus(1'b0, 5'h18, 32'h0);
    chk(q, 32'h0);
    $display("test reset done");
    // Period of ten counts is 40 clocks; a low duty keeps reversals safe.
    bus(1'b1, REG_PERIOD, 32'h9);
    bus(1'b1, REG_DUTY, 32'hC);
    bus(1'b1, REG_DEADBAND, 32'h1);
    // Dead-band of one unit is on throughout; only half-bridge may show it.
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, REG_MODE, {24'h0, 2'(m), 6'h0C});
      repeat (80) @(posedge clk_sys);
      pins(exp_tab[m]);
    end
    $display("test modes done");
    bus(1'b1, REG_MODE, 32'h4C);
    do bus(1'b0, REG_STATUS, 32'h0); while (q[14] !== 1'b1);
    @(negedge clk_sys);
    chk(pad, 4'h1);
    repeat (20) @(posedge clk_sys);
    pins('{40, 0, 0, 12});
    bus(1'b1, REG_MODE, 32'h4F);
    repeat (80) @(posedge clk_sys);
    pins('{0, 40, 40, 28});
    bus(1'b1, REG_MODE, 32'h8C);
    bus(1'b1, REG_DEADBAND, 32'h4);
    repeat (80) @(posedge clk_sys);
    pins('{0, 12, -1, -1});
    bus(1'b1, REG_MODE, 32'h4C);
    $display("test direction and dead-band done");
    // Pair A/C shuts high, pair B/D floats; running forward has C low, B driven.
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 2; k++) begin
        bus(1'b1, REG_SHUTDOWN, 32'(s * 16 + 6));
        repeat (48) @(posedge clk_sys);
        cmp_req <= (k == 0);
        flt_req <= (k == 1);
        @(negedge clk_sys);
        chk({bridge_pins.oe[1], pad[2]}, s[k] ? 2'b01 : 2'b10);
        bus(1'b0, REG_SHUTDOWN, 32'h0);
        chk(q[7], s[k]);
        cmp_req <= 1'b0;
        flt_req <= 1'b0;
      end
    end
    $display("test shutdown sources done");
    flt_req <= 1'b1;
    bus(1'b1, REG_SHUTDOWN, 32'h26);
    bus(1'b0, REG_SHUTDOWN, 32'h0);
    chk(q[7], 1'b1);
    flt_req <= 1'b0;
    repeat (50) @(posedge clk_sys);
    chk(pad[2], 1'b1);
    bus(1'b1, REG_SHUTDOWN, 32'h26);
    bus(1'b0, REG_SHUTDOWN, 32'h0);
    chk(q[7], 1'b0);
    repeat (40) @(posedge clk_sys);
    pins('{40, 0, 0, 12});
    bus(1'b1, REG_DEADBAND, 32'h81);
    flt_req <= 1'b1;
    repeat (4) @(posedge clk_sys);
    bus(1'b0, REG_SHUTDOWN, 32'h0);
    chk(q[7], 1'b1);
    flt_req <= 1'b0;
    repeat (4) @(posedge clk_sys);
    bus(1'b0, REG_SHUTDOWN, 32'h0);
    chk(q[7], 1'b0);
    bus(1'b1, REG_DEADBAND, 32'h01);
    bus(1'b1, REG_SHUTDOWN, 32'hA6);
    bus(1'b0, REG_SHUTDOWN, 32'h0);
    chk({q[7], pad[2]}, 2'b11);
    bus(1'b1, REG_DEADBAND, 32'h81);
    bus(1'b0, REG_SHUTDOWN, 32'h0);
    chk(q[7], 1'b0);
    repeat (40) @(posedge clk_sys);
    pins('{40, 0, 0, 12});
    $display("test restart done");
    end_sim();
  end
endmodule
